/* File: verilog/gst_pkg.sv */
`default_nettype none
package gst_pkg;
    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [2:0] OFS_TIMER_CONTROL = 3'h0;
    localparam logic [2:0] OFS_GATE_CONTROL  = 3'h1;
    localparam logic [2:0] OFS_COUNT_LOW     = 3'h2;
    localparam logic [2:0] OFS_COUNT_HIGH    = 3'h3;
    localparam logic [2:0] OFS_OSC_ENABLE    = 3'h4;
    localparam logic [2:0] OFS_CLOCK_SELECT  = 3'h5;
    localparam logic [2:0] OFS_INT_STATUS    = 3'h6;
    localparam logic [2:0] OFS_INT_MASK      = 3'h7;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_ON_BIT    = 0;
    localparam int CTRL_WIDE_BIT  = 1;
    localparam int CTRL_SYNC_BIT  = 2;
    localparam int CTRL_PS_LSB    = 4;
    localparam int GATE_STATE_BIT = 2;
    localparam int GATE_POL_BIT   = 6;
    localparam int GATE_ON_BIT    = 7;
    localparam int OSC_EN_BIT     = 3;
    localparam int STAT_OVF_BIT   = 0;
    localparam int STAT_GATE_BIT  = 1;

    // ------------------------------------------------------------------
    // Write masks and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_WMASK   = 8'h37;
    localparam logic [7:0] GATE_WMASK   = 8'hc0;
    localparam logic [7:0] OSC_WMASK    = 8'h08;
    localparam logic [7:0] CLKSEL_WMASK = 8'h03;
    localparam logic [7:0] STAT_WMASK   = 8'h03;
    localparam logic [7:0] REG_RESET    = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;

    // ------------------------------------------------------------------
    // Count clock select codes
    // ------------------------------------------------------------------
    localparam logic [1:0] CLK_FOSC     = 2'h0;
    localparam logic [1:0] CLK_FOSC_DV4 = 2'h1;
    localparam logic [1:0] CLK_EXT_PIN  = 2'h2;
    localparam logic [1:0] CLK_LP_OSC   = 2'h3;

    // ------------------------------------------------------------------
    // Timing figures
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS          = 10;
    localparam int LOWPOWER_OSC_HZ        = 32768;
    localparam logic [15:0] SETTLE_PRELOAD = 16'hfc00;
    localparam int SETTLE_CLOCKS          = 1024;
endpackage
`default_nettype wire

/* File: verilog/gst_timer.sv */
// ------------------------------------------------------------------
// Overview of operation
// - Prescale field 11, 10, 01 divides the count clock by 8, 4, 2.
// - Prescale counter hidden from software, cleared by any count byte write.
// - Oscillator enable bit starts the crystal oscillator; it keeps running in sleep.
// - Rollover sets overflow flag; software may time oscillator settling from FC00h.
// - Sync control bit set: external clock counted without synchronisation.
// - Unsynchronised external counting continues in sleep; overflow can wake.
// - Switching sync modes may lose or add one count.
// - Count byte reads are valid while counting an unsynchronised external clock.
// - Gate control register enables gating and sets its polarity.
// - Gated: count only while gate input equals polarity, else hold.
// - Gating off: count on every timer clock.
// - Run bit enables timer; clearing it also clears the gate flip-flop.
// ------------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
module gst_timer (
    input  wire logic                       ref_clk,         // System clock, 100 MHz
    input  wire logic                       rst_n,           // Synchronous reset, active low
    input  wire logic [gst_pkg::ADDR_W-1:0] busAddr,         // Register address
    input  wire logic [gst_pkg::DATA_W-1:0] busWrData,       // Write data
    input  wire logic                       busWrStb,        // Write strobe
    input  wire logic                       busRdStb,        // Read strobe
    output logic      [gst_pkg::DATA_W-1:0] busRdData,       // Read data, cycle after strobe
    input  wire logic                       extClkPin,       // External count clock pin
    input  wire logic                       crystalInputPin, // Low-power oscillator output
    input  wire logic                       gatingInput,     // Count gate input
    input  wire logic                       sleepMode,       // Processor asleep
    output logic                            irq,             // Level interrupt
    output logic                            wakeReq,         // Wake request in sleep
    output logic                            crystalAmpOn     // Crystal amplifier enable
);
    import gst_pkg::*;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [7:0]  ctrl_ff;
    logic [7:0]  gateCtrl_ff;
    logic [7:0]  oscillator_enable_reg_ff;
    logic [7:0]  clkSel_ff;
    logic [7:0]  status_ff;
    logic [7:0]  mask_ff;
    logic [15:0] count_ff;
    logic [7:0]  highBuf_ff;
    logic [2:0]  presCnt_ff;
    logic [1:0]  fosc4_ff;
    logic        extMeta_ff;
    logic        extSync_ff;
    logic        extSyncDly_ff;
    logic        extDirect_ff;
    logic        extDirectDly_ff;
    logic        gateFf_ff;
    logic        gateActDly_ff;

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    // Strobe qualified by address
    function automatic logic regHit(input logic stb, input logic [2:0] addr, input logic [2:0] ofs);
        regHit = stb && (addr == ofs);
    endfunction

    // Prescale field to terminal count of the prescale counter
    function automatic logic [2:0] psLimit(input logic [1:0] sel);
        case (sel)
            2'h3:    psLimit = 3'h7;
            2'h2:    psLimit = 3'h3;
            2'h1:    psLimit = 3'h1;
            default: psLimit = 3'h0;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    wire wrCtrl   = regHit(busWrStb, busAddr, OFS_TIMER_CONTROL);
    wire wrGate   = regHit(busWrStb, busAddr, OFS_GATE_CONTROL);
    wire wrLow    = regHit(busWrStb, busAddr, OFS_COUNT_LOW);
    wire wrHigh   = regHit(busWrStb, busAddr, OFS_COUNT_HIGH);
    wire wrOsc    = regHit(busWrStb, busAddr, OFS_OSC_ENABLE);
    wire wrClkSel = regHit(busWrStb, busAddr, OFS_CLOCK_SELECT);
    wire wrStat   = regHit(busWrStb, busAddr, OFS_INT_STATUS);
    wire wrMask   = regHit(busWrStb, busAddr, OFS_INT_MASK);
    wire rdLow    = regHit(busRdStb, busAddr, OFS_COUNT_LOW);
    wire cntWr    = wrLow | wrHigh;

    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------
    wire       runOn    = ctrl_ff[CTRL_ON_BIT];
    wire       wideAcc  = ctrl_ff[CTRL_WIDE_BIT];
    wire       syncOff  = ctrl_ff[CTRL_SYNC_BIT];
    wire [1:0] psSel    = ctrl_ff[CTRL_PS_LSB +: 2];
    wire       gateOn   = gateCtrl_ff[GATE_ON_BIT];
    wire       gatePol  = gateCtrl_ff[GATE_POL_BIT];
    wire       oscOn    = oscillator_enable_reg_ff[OSC_EN_BIT];
    wire [1:0] srcSel   = clkSel_ff[1:0];
    wire       extSel   = (srcSel == CLK_EXT_PIN) || (srcSel == CLK_LP_OSC);
    wire       unsyncExt = extSel & syncOff;

    // ------------------------------------------------------------------
    // Count clock sources
    // ------------------------------------------------------------------
    // Crystal only delivers edges while its oscillator is enabled
    wire extRaw   = (srcSel == CLK_LP_OSC) ? (crystalInputPin & oscOn) : extClkPin;
    wire syncEdge = extSync_ff & ~extSyncDly_ff;
    wire dirEdge  = extDirect_ff & ~extDirectDly_ff;
    // Internal sources ignore the sync bit; the two external paths differ in
    // latency, so a mode change can drop or repeat one edge
    wire intEdge  = (srcSel == CLK_FOSC) ? 1'b1 : (fosc4_ff == 2'h3);
    wire extEdge  = syncOff ? dirEdge : syncEdge;
    wire srcEdge  = extSel ? extEdge : intEdge;

    // ------------------------------------------------------------------
    // Count qualification
    // ------------------------------------------------------------------
    wire gateActive = (gateFf_ff == gatePol);
    wire gateOk     = ~gateOn | gateActive;
    wire sleepOk    = ~sleepMode | unsyncExt;
    wire srcAdv     = srcEdge & runOn & gateOk & sleepOk;
    wire [2:0] presLimit = psLimit(psSel);
    // Compare with >= so a smaller ratio chosen mid-count restarts at once
    wire presHit    = (presCnt_ff >= presLimit);
    wire countInc   = srcAdv & presHit;

    // ------------------------------------------------------------------
    // Events
    // ------------------------------------------------------------------
    wire ovfEvent  = countInc & ~cntWr & (&count_ff);
    wire gateClose = gateOn & gateActDly_ff & ~gateActive;
    wire [7:0] evtBits  = {6'h00, gateClose, ovfEvent};
    wire [7:0] clrBits  = wrStat ? (busWrData & STAT_WMASK) : 8'h00;
    wire [7:0] nxt_status = (status_ff & ~clrBits) | evtBits;
    wire       pendIrq  = |(status_ff & mask_ff);

    // ------------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------------
    // Count reads come from the system-clock copy, so they are always whole
    wire [7:0] gateRd = (gateCtrl_ff & GATE_WMASK) | ({7'h00, gateFf_ff} << GATE_STATE_BIT);
    wire [7:0] highRd = wideAcc ? highBuf_ff : count_ff[15:8];
    wire [7:0] rdMux  = (busAddr == OFS_TIMER_CONTROL) ? ctrl_ff :
                        (busAddr == OFS_GATE_CONTROL)  ? gateRd :
                        (busAddr == OFS_COUNT_LOW)     ? count_ff[7:0] :
                        (busAddr == OFS_COUNT_HIGH)    ? highRd :
                        (busAddr == OFS_OSC_ENABLE)    ? oscillator_enable_reg_ff :
                        (busAddr == OFS_CLOCK_SELECT)  ? clkSel_ff :
                        (busAddr == OFS_INT_STATUS)    ? status_ff : mask_ff;

    // ------------------------------------------------------------------
    // Next count
    // ------------------------------------------------------------------
    // A count write takes precedence over a coinciding increment
    logic [15:0] nxt_count;
    always_comb begin
        nxt_count = count_ff;
        if (wrLow && wideAcc) begin
            nxt_count = {highBuf_ff, busWrData};
        end else if (wrLow) begin
            nxt_count[7:0] = busWrData;
        end else if (wrHigh && !wideAcc) begin
            nxt_count[15:8] = busWrData;
        end else if (countInc && !cntWr) begin
            nxt_count = count_ff + 16'h0001;
        end
    end

    // Prescale counter, not mapped to any register
    logic [2:0] nxt_presCnt;
    always_comb begin
        nxt_presCnt = presCnt_ff;
        if (cntWr) begin
            nxt_presCnt = 3'h0;
        end else if (srcAdv) begin
            nxt_presCnt = presHit ? 3'h0 : presCnt_ff + 3'h1;
        end
    end

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_ff     <= REG_RESET;
            gateCtrl_ff <= REG_RESET;
            oscillator_enable_reg_ff    <= REG_RESET;
            clkSel_ff   <= REG_RESET;
            mask_ff     <= REG_RESET;
        end else begin
            if (wrCtrl) ctrl_ff <= busWrData & CTRL_WMASK;
            if (wrGate) gateCtrl_ff <= busWrData & GATE_WMASK;
            if (wrOsc) oscillator_enable_reg_ff <= busWrData & OSC_WMASK;
            if (wrClkSel) clkSel_ff <= busWrData & CLKSEL_WMASK;
            if (wrMask) mask_ff <= busWrData & STAT_WMASK;
        end
    end

    // Status, event set wins over write-one clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            status_ff <= REG_RESET;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // ------------------------------------------------------------------
    // Counter, prescaler and high-byte buffer
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            count_ff   <= COUNT_RESET;
            presCnt_ff <= 3'h0;
            highBuf_ff <= REG_RESET;
        end else begin
            count_ff   <= nxt_count;
            presCnt_ff <= nxt_presCnt;
            if (wrHigh && wideAcc) begin
                highBuf_ff <= busWrData;
            end else if (rdLow && wideAcc) begin
                highBuf_ff <= count_ff[15:8];
            end
        end
    end

    // ------------------------------------------------------------------
    // Clock source conditioning
    // ------------------------------------------------------------------
    // Two-stage synchroniser plus a separate single-sample direct path
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fosc4_ff        <= 2'h0;
            extMeta_ff      <= 1'b0;
            extSync_ff      <= 1'b0;
            extSyncDly_ff   <= 1'b0;
            extDirect_ff    <= 1'b0;
            extDirectDly_ff <= 1'b0;
        end else begin
            fosc4_ff        <= fosc4_ff + 2'h1;
            extMeta_ff      <= extRaw;
            extSync_ff      <= extMeta_ff;
            extSyncDly_ff   <= extSync_ff;
            extDirect_ff    <= extRaw;
            extDirectDly_ff <= extDirect_ff;
        end
    end

    // Gate flip-flop, held clear while the timer is off
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            gateFf_ff     <= 1'b0;
            gateActDly_ff <= 1'b0;
        end else begin
            gateFf_ff     <= runOn ? gatingInput : 1'b0;
            gateActDly_ff <= runOn & gateActive;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            busRdData    <= REG_RESET;
            irq          <= 1'b0;
            wakeReq      <= 1'b0;
            crystalAmpOn <= 1'b0;
        end else begin
            busRdData    <= busRdStb ? rdMux : REG_RESET;
            irq          <= pendIrq;
            wakeReq      <= sleepMode & pendIrq;
            crystalAmpOn <= oscOn;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    prescale_step_a: assert property (
        srcAdv && !cntWr && (presCnt_ff < presLimit) |=> presCnt_ff == $past(presCnt_ff) + 3'h1)
        else $error("prescaler did not advance");
    no_divide_a: assert property (
        (psSel == 2'h0) && srcAdv && !cntWr |=> count_ff == $past(count_ff) + 16'h0001)
        else $error("undivided count missed an edge");
    prescale_clear_a: assert property (
        cntWr |=> presCnt_ff == 3'h0)
        else $error("prescaler not cleared by count write");
    osc_run_a: assert property (
        oscOn ##1 oscOn |-> crystalAmpOn)
        else $error("oscillator amplifier off while enabled");
    overflow_flag_a: assert property (
        (&count_ff) && countInc && !cntWr |=> status_ff[STAT_OVF_BIT] ##1 status_ff[STAT_OVF_BIT] || $past(wrStat))
        else $error("overflow flag not set on rollover");
    sleep_hold_a: assert property (
        sleepMode && !unsyncExt && !cntWr |=> count_ff == $past(count_ff))
        else $error("count moved in sleep without unsynchronised clock");
    gate_hold_a: assert property (
        gateOn && (gateFf_ff != gatePol) && !cntWr |=> $stable(count_ff))
        else $error("count moved while gate inactive");
    gate_clear_a: assert property (
        !runOn [*2] |-> gateFf_ff == 1'b0 && !countInc)
        else $error("gate flip-flop not cleared while stopped");
    wide_latch_a: assert property (
        rdLow && wideAcc && !wrHigh ##1 busRdStb && (busAddr == OFS_COUNT_HIGH) && !$past(wrLow)
        |=> busRdData == $past(count_ff[15:8], 2))
        else $error("high byte not from the low-byte snapshot");
    irq_level_a: assert property (
        pendIrq |=> irq)
        else $error("interrupt not raised for pending status");
    // Clock paths, gating register and wide count write
    unsync_count_a: assert property (
        unsyncExt && dirEdge && runOn && !gateOn && (psSel == 2'h0) && !cntWr
        |=> count_ff == $past(count_ff) + 16'h0001)
        else $error("unsynchronised edge not counted");
    internal_clock_a: assert property (
        (srcSel == CLK_FOSC) && runOn && !gateOn && !sleepMode && (psSel == 2'h0) && !cntWr
        |=> count_ff == $past(count_ff) + 16'h0001)
        else $error("system clock edge not counted");
    gate_off_a: assert property (
        !gateOn && (gateFf_ff != gatePol) && srcEdge && runOn && !sleepMode && (psSel == 2'h0) && !cntWr
        |=> count_ff == $past(count_ff) + 16'h0001)
        else $error("ungated count held by gate input");
    gate_reg_a: assert property (
        wrGate |=> gateOn == $past(busWrData[GATE_ON_BIT]) && gatePol == $past(busWrData[GATE_POL_BIT]))
        else $error("gate control fields not taken from the write");
    wide_write_a: assert property (
        wrLow && wideAcc |=> count_ff == {$past(highBuf_ff), $past(busWrData)})
        else $error("wide low-byte write did not load the buffered pair");

    // Main scenarios the bench is expected to reach
    overflow_c:   cover property (ovfEvent ##[1:3] irq);
    wide_read_c:  cover property (rdLow && wideAcc ##1 busRdStb && (busAddr == OFS_COUNT_HIGH));
    gated_hold_c: cover property (gateOn && !gateActive && srcEdge && runOn);
    sleep_cnt_c:  cover property (sleepMode && unsyncExt && countInc);
    gate_shut_c:  cover property (gateClose);
endmodule
`default_nettype wire

/* File: test/gst_ext_clock_src.sv */
`timescale 1ns/1ns
`default_nettype none
module gst_ext_clock_src #(
    parameter int HALF = 4
) (
    input  wire logic ref_clk,        // System clock
    input  wire logic rst_n,          // Synchronous reset, active low
    input  wire logic srcOn,          // Source running
    output logic      extClkPin,      // External count clock
    output logic      crystalInputPin // Low-power oscillator clock
);
    int phase;

    // Square wave of 2*HALF system cycles, parked low while stopped
    always @(posedge ref_clk) begin
        if (!rst_n || !srcOn) begin
            phase <= 0;
            extClkPin <= 1'b0;
            crystalInputPin <= 1'b0;
        end else begin
            phase <= (phase == HALF - 1) ? 0 : phase + 1;
            if (phase == HALF - 1) begin
                extClkPin <= ~extClkPin;
                crystalInputPin <= ~crystalInputPin;
            end
        end
    end
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import gst_pkg::*;
    // ------------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------------
    logic       ref_clk     = 1'b0;
    logic       rst_n       = 1'b0;
    logic [2:0] busAddr     = 3'h0;
    logic [7:0] busWrData   = 8'h00;
    logic       busWrStb    = 1'b0;
    logic       busRdStb    = 1'b0;
    logic       gatingInput = 1'b0;
    logic       sleepMode   = 1'b0;
    logic       srcOn       = 1'b0;
    logic [7:0] busRdData;
    logic [7:0] rv;
    logic [7:0] rv2;
    wire        extClkPin, crystalInputPin, irq, wakeReq, crystalAmpOn;
    int         bad_count   = 0;
    int         checks_done = 0;
    int         n;

    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    gst_timer dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .busAddr(busAddr), .busWrData(busWrData),
        .busWrStb(busWrStb), .busRdStb(busRdStb), .busRdData(busRdData),
        .extClkPin(extClkPin), .crystalInputPin(crystalInputPin), .gatingInput(gatingInput),
        .sleepMode(sleepMode), .irq(irq), .wakeReq(wakeReq), .crystalAmpOn(crystalAmpOn)
    );

    gst_ext_clock_src src (
        .ref_clk(ref_clk), .rst_n(rst_n), .srcOn(srcOn),
        .extClkPin(extClkPin), .crystalInputPin(crystalInputPin)
    );

    // ------------------------------------------------------------------
    // Bus access, comparison and closing
    // ------------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        busWrStb <= 1'b1;
        busAddr <= a;
        busWrData <= d;
        @(posedge ref_clk);
        busWrStb <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        busRdStb <= 1'b1;
        busAddr <= a;
        @(posedge ref_clk);
        busRdStb <= 1'b0;
        #1 d = busRdData;
    endtask

    // Bounded wait for the interrupt line
    task automatic wait_irq(input int lim, output int cnt);
        cnt = 0;
        while (irq !== 1'b1) begin
            @(posedge ref_clk);
            #1 cnt++;
            if (cnt > lim) begin
                bad_count++;
                final_report();
            end
        end
    endtask

    // Configure, settle, then count increments over 64 cycles
    task automatic span(input logic [7:0] ctrl, input logic [7:0] gate, input logic [1:0] sel,
                        input logic gin, input logic slp, input logic [7:0] exp);
        wr(OFS_GATE_CONTROL, gate);
        wr(OFS_CLOCK_SELECT, {6'h00, sel});
        wr(OFS_TIMER_CONTROL, ctrl);
        gatingInput <= gin;
        sleepMode <= slp;
        repeat (8) @(posedge ref_clk);
        rd(OFS_COUNT_LOW, rv);
        repeat (62) @(posedge ref_clk);
        rd(OFS_COUNT_LOW, rv2);
        chk(rv2 - rv, exp);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        srcOn <= 1'b1;
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0], rv);
            chk(rv, REG_RESET);
        end
        wr(OFS_TIMER_CONTROL, 8'hff);
        rd(OFS_TIMER_CONTROL, rv);
        chk(rv, CTRL_WMASK);
        for (int p = 0; p < 4; p++) begin
            span({2'h0, p[1:0], 4'h1}, 8'h00, CLK_FOSC, 1'b0, 1'b0, 8'(64 >> p));
        end
        for (int g = 0; g < 4; g++) begin
            span(8'h01, {1'b1, g[1], 6'h00}, CLK_FOSC, g[0], 1'b0, (g[1] == g[0]) ? 8'h40 : 8'h00);
        end
        span(8'h01, 8'h40, CLK_FOSC, 1'b0, 1'b0, 8'h40);
        span(8'h01, 8'hc0, CLK_FOSC, 1'b1, 1'b0, 8'h40);
        rd(OFS_GATE_CONTROL, rv);
        chk(rv, 8'hc4);
        span(8'h00, 8'hc0, CLK_FOSC, 1'b1, 1'b0, 8'h00);
        rd(OFS_GATE_CONTROL, rv);
        chk(rv, 8'hc0);
        span(8'h05, 8'h00, CLK_FOSC_DV4, 1'b0, 1'b0, 8'h10);
        span(8'h01, 8'h00, CLK_FOSC_DV4, 1'b0, 1'b0, 8'h10);
        span(8'h05, 8'h00, CLK_FOSC, 1'b0, 1'b0, 8'h40);
        span(8'h01, 8'h00, CLK_EXT_PIN, 1'b0, 1'b0, 8'h08);
        span(8'h05, 8'h00, CLK_EXT_PIN, 1'b0, 1'b0, 8'h08);
        span(8'h05, 8'h00, CLK_EXT_PIN, 1'b0, 1'b1, 8'h08);
        span(8'h01, 8'h00, CLK_EXT_PIN, 1'b0, 1'b1, 8'h00);
        span(8'h01, 8'h00, CLK_FOSC, 1'b0, 1'b1, 8'h00);
        span(8'h01, 8'h00, CLK_LP_OSC, 1'b0, 1'b0, 8'h00);
        wr(OFS_OSC_ENABLE, 8'h08);
        span(8'h05, 8'h00, CLK_LP_OSC, 1'b0, 1'b1, 8'h08);
        chk({7'h00, crystalAmpOn}, 8'h01);
        // Prescaler restart on a count write, divide by 8
        span(8'h31, 8'h00, CLK_FOSC, 1'b0, 1'b0, 8'h08);
        wr(OFS_COUNT_LOW, 8'h00);
        repeat (2) @(posedge ref_clk);
        rd(OFS_COUNT_LOW, rv);
        chk(rv, 8'h00);
        // Paired byte access with the timer stopped
        wr(OFS_TIMER_CONTROL, 8'h02);
        wr(OFS_COUNT_HIGH, 8'h12);
        wr(OFS_COUNT_LOW, 8'h34);
        wr(OFS_COUNT_HIGH, 8'h56);
        rd(OFS_COUNT_LOW, rv);
        chk(rv, 8'h34);
        rd(OFS_COUNT_HIGH, rv);
        chk(rv, 8'h12);
        wr(OFS_TIMER_CONTROL, 8'h00);
        wr(OFS_COUNT_HIGH, 8'h56);
        rd(OFS_COUNT_HIGH, rv);
        chk(rv, 8'h56);
        // Overflow interrupt: raise, clear, then masked
        wr(OFS_INT_STATUS, 8'h03);
        wr(OFS_INT_MASK, 8'h01);
        wr(OFS_CLOCK_SELECT, {6'h00, CLK_FOSC});
        wr(OFS_COUNT_HIGH, 8'hff);
        wr(OFS_COUNT_LOW, 8'hf0);
        wr(OFS_TIMER_CONTROL, 8'h01);
        wait_irq(100, n);
        wr(OFS_TIMER_CONTROL, 8'h00);
        rd(OFS_INT_STATUS, rv);
        chk(rv, 8'h01);
        wr(OFS_INT_STATUS, 8'h01);
        repeat (2) @(posedge ref_clk);
        chk({7'h00, irq}, 8'h00);
        wr(OFS_INT_MASK, 8'h00);
        wr(OFS_COUNT_HIGH, 8'hff);
        wr(OFS_COUNT_LOW, 8'hf0);
        wr(OFS_TIMER_CONTROL, 8'h01);
        repeat (40) @(posedge ref_clk);
        wr(OFS_TIMER_CONTROL, 8'h00);
        rd(OFS_INT_STATUS, rv);
        chk(rv, 8'h01);
        chk({7'h00, irq}, 8'h00);
        // Oscillator settling check from the preload, asleep
        wr(OFS_INT_STATUS, 8'h03);
        wr(OFS_INT_MASK, 8'h01);
        wr(OFS_CLOCK_SELECT, {6'h00, CLK_LP_OSC});
        wr(OFS_COUNT_HIGH, SETTLE_PRELOAD[15:8]);
        wr(OFS_COUNT_LOW, SETTLE_PRELOAD[7:0]);
        sleepMode <= 1'b1;
        wr(OFS_TIMER_CONTROL, 8'h05);
        wait_irq(9000, n);
        chk({7'h00, (n > 8100) && (n < 8250)}, 8'h01);
        @(posedge ref_clk);
        #1 chk({7'h00, wakeReq}, 8'h01);
        final_report();
    end
endmodule
`default_nettype wire
